//--- design/ohb_boot_decoder.v
// header decoder and start-up stage sequencer
// What this block does
// RL1: calibration upper half A5A5 means calibrated, 0000 means none calibrated
// RL2: calibration bits 5..0 flag valid trims, bits 15..6 ignored
// RL3: sleep source word 00 selects crystal, AA selects precision RC
// RL4: package word 00 chip-scale, AA QFN40, 55 QFN48, 99 bare die
// RL5: byte codes must be repeated in all four bytes to match
// RL6: application present only when both marker words hold their values
// RL7: both markers match gives normal boot, else development boot
// RL8: debug enable word decides debug pin mapping, blank keeps it enabled
// RL9: debug word 00 keeps debug enabled, AA disables it
// RL10: length word gives 32-bit words for the mirroring engine
// RL11: device address comes from two words starting at 7FD4
// RL12: signature selector word picks algorithm, check is optional
// RL13: trim CRC word read and offered before trims are applied
// RL14: IQ trim word is loaded into radio configuration fields
// RL15: customer area and reserved words are never interpreted
// RL16: power sequencing, then mirroring, then boot code, strictly in order
// RL17: hardwired power stage enables regulators and waits for good supplies
// RL18: hardwired mirroring stage copies memory before processor starts
// RL19: boot code runs on power-up or hardware reset, not wake-up
// RL20: cold-start flag set at power-up tells cold start from wake-up
// RL21: unknown flag codes count as unset and take the default
// RL22: header memory is only read, never written
`timescale 1ns/10ps
`default_nettype none
`include "ohb_consts.vh"
module ohb_boot_decoder
(
  // clock and reset
  input  wire        CLOCK_I,
  input  wire        RST_N_I,
  // apb slave
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  // power sequencer and wake source
  input  wire        WAKE_REQ_I,
  input  wire        SUPPLY_GOOD_I,
  output reg         REG_EN_O,
  // programmable memory read port
  output reg         MEM_RD_O,
  output reg  [14:0] MEM_ADDR_O,
  input  wire        MEM_ACK_I,
  input  wire [31:0] MEM_RDATA_I,
  // mirroring engine
  output reg         MIRROR_START_O,
  output reg  [31:0] MIRROR_LEN_O,
  input  wire        MIRROR_DONE_I,
  // boot processor and decoded header
  output reg         CPU_RUN_O,
  output reg         NORMAL_MODE_O,
  output reg         DEBUG_EN_O,
  output reg         SLEEP_RC_SEL_O,
  output reg  [2:0]  PACKAGE_O,
  output reg  [1:0]  SIG_SEL_O,
  output reg  [31:0] IQ_TRIM_O
);

  // ********************
  // state codes
  // ********************
  localparam [2:0] ST_POWER  = 3'h0;
  localparam [2:0] ST_HEADER = 3'h1;
  localparam [2:0] ST_MIRROR = 3'h2;
  localparam [2:0] ST_WAITSW = 3'h3;
  localparam [2:0] ST_RUN    = 3'h4;
  localparam [2:0] ST_SLEEP  = 3'h5;

  // byte code replicated into a whole word
  function [31:0] rep4;
    input [7:0] b;
    begin
      rep4 = {b, b, b, b};
    end
  endfunction

  // header word address for each fetch slot
  function [14:0] slot_addr;
    input [3:0] s;
    begin
      case (s)
        4'h0:    slot_addr = `OHB_ADDR_DBG_EN;
        4'h1:    slot_addr = `OHB_ADDR_MIRROR_LEN;
        4'h2:    slot_addr = `OHB_ADDR_DEV_ADDR0;
        4'h3:    slot_addr = `OHB_ADDR_DEV_ADDR1;
        4'h4:    slot_addr = `OHB_ADDR_SIG_SEL;
        4'h5:    slot_addr = `OHB_ADDR_CAL_FLAGS;
        4'h6:    slot_addr = `OHB_ADDR_SLEEP_SRC;
        4'h7:    slot_addr = `OHB_ADDR_PACKAGE;
        4'h8:    slot_addr = `OHB_ADDR_TRIM_CRC;
        4'h9:    slot_addr = `OHB_ADDR_IQ_TRIM;
        4'hA:    slot_addr = `OHB_ADDR_APP_MARK2;
        default: slot_addr = `OHB_ADDR_APP_MARK1;
      endcase
    end
  endfunction

  // ********************
  // synchronisers
  // ********************
  reg [1:0] wake_s_q;
  reg [1:0] good_s_q;
  reg [1:0] mdone_s_q;
  always @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      wake_s_q  <= 2'h0;
      good_s_q  <= 2'h0;
      mdone_s_q <= 2'h0;
    end
    else
    begin
      wake_s_q  <= {wake_s_q[0], WAKE_REQ_I};
      good_s_q  <= {good_s_q[0], SUPPLY_GOOD_I};
      mdone_s_q <= {mdone_s_q[0], MIRROR_DONE_I};
    end
  end
  wire wake_s  = wake_s_q[1];
  wire good_s  = good_s_q[1];
  wire mdone_s = mdone_s_q[1];

  // ********************
  // header fetch
  // ********************
  reg  [2:0]  state_q;
  reg  [3:0]  slot_q;
  reg         fetch_go_q;
  wire        fetch_done;
  wire [31:0] fetch_data;
  wire        mem_rd;
  wire [14:0] mem_addr;

  // RL22 read only
  ohb_word_fetch u_fetch
  (
    .clk_i       (CLOCK_I),
    .rst_n_i     (RST_N_I),
    .start_i     (fetch_go_q),
    .addr_i      (slot_addr(slot_q)),
    .done_o      (fetch_done),
    .data_o      (fetch_data),
    .mem_rd_o    (mem_rd),
    .mem_addr_o  (mem_addr),
    .mem_ack_i   (MEM_ACK_I),
    .mem_rdata_i (MEM_RDATA_I)
  );

  // RL15 customer area skipped
  reg [31:0] dbg_w_q;
  reg [31:0] dev0_q;
  reg [31:0] dev1_q;
  reg [31:0] sig_w_q;
  reg [31:0] cal_w_q;
  reg [31:0] slp_w_q;
  reg [31:0] pkg_w_q;
  reg [31:0] crc_q;
  reg [31:0] mark2_q;
  reg [31:0] mark1_q;

  // ********************
  // decode
  // ********************
  // RL1 calibration summary
  wire cal_done = (cal_w_q[31:16] == `OHB_CAL_DONE);
  // RL2 per-trim valid flags, reserved bits dropped
  wire [5:0] cal_valid = cal_done ? cal_w_q[`OHB_CAL_VALID_MSB:0] : 6'h00;
  // RL6 application marker check
  wire app_ok = (mark1_q == `OHB_APP_MARK1_VAL) && (mark2_q == `OHB_APP_MARK2_VAL);
  // RL9 debug only off for the replicated AA code
  wire dbg_off = (dbg_w_q == rep4(`OHB_CODE_AA));

  reg [2:0] pkg_dec;
  reg [1:0] sig_dec;
  always @*
  begin
    // RL4 package codes, RL5 replicated compare
    if (pkg_w_q == rep4(`OHB_CODE_00))
      pkg_dec = `OHB_PKG_CSP34;
    else if (pkg_w_q == rep4(`OHB_CODE_AA))
      pkg_dec = `OHB_PKG_QFN40;
    else if (pkg_w_q == rep4(`OHB_CODE_55))
      pkg_dec = `OHB_PKG_QFN48;
    else if (pkg_w_q == rep4(`OHB_CODE_99))
      pkg_dec = `OHB_PKG_BARE_DIE;
    else
      pkg_dec = `OHB_PKG_UNKNOWN;
    // RL12 signature selector, unknown means none
    if (sig_w_q == rep4(`OHB_CODE_AA))
      sig_dec = `OHB_SIG_MD5;
    else if (sig_w_q == rep4(`OHB_CODE_55))
      sig_dec = `OHB_SIG_SHA1;
    else if (sig_w_q == rep4(`OHB_CODE_FF))
      sig_dec = `OHB_SIG_CRC32;
    else
      sig_dec = `OHB_SIG_NONE;
  end

  // ********************
  // control state
  // ********************
  reg cold_q;
  reg boot_go_q;
  reg hdr_valid_q;
  reg [31:0] len_q;
  reg [31:0] iq_q;

  // apb write strobe, access phase with zero wait states
  wire apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
  wire boot_go_wr = apb_wr && (PADDR_I == `OHB_REG_CTRL) && PWDATA_I[`OHB_CTRL_BOOT_GO];

  always @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_q     <= ST_POWER;
      slot_q      <= 4'h0;
      fetch_go_q  <= 1'b0;
      // RL20 cold start marked by reset
      cold_q      <= 1'b1;
      boot_go_q   <= 1'b0;
      hdr_valid_q <= 1'b0;
      dbg_w_q     <= 32'h00000000;
      len_q       <= 32'h00000000;
      dev0_q      <= 32'h00000000;
      dev1_q      <= 32'h00000000;
      sig_w_q     <= 32'h00000000;
      cal_w_q     <= 32'h00000000;
      slp_w_q     <= 32'h00000000;
      pkg_w_q     <= 32'h00000000;
      crc_q       <= 32'h00000000;
      iq_q        <= 32'h00000000;
      mark2_q     <= 32'h00000000;
      mark1_q     <= 32'h00000000;
    end
    else
    begin
      fetch_go_q <= 1'b0;
      if (boot_go_wr)
        boot_go_q <= 1'b1;
      case (state_q)
        // RL17 regulators on, wait for good supplies
        ST_POWER:
        begin
          if (good_s)
          begin
            // RL16 header is read before mirroring starts
            state_q    <= ST_HEADER;
            slot_q     <= 4'h0;
            fetch_go_q <= 1'b1;
          end
        end
        ST_HEADER:
        begin
          if (fetch_done)
          begin
            case (slot_q)
              4'h0:    dbg_w_q <= fetch_data;
              // RL10 mirroring length
              4'h1:    len_q   <= fetch_data;
              // RL11 device address pair
              4'h2:    dev0_q  <= fetch_data;
              4'h3:    dev1_q  <= fetch_data;
              4'h4:    sig_w_q <= fetch_data;
              4'h5:    cal_w_q <= fetch_data;
              4'h6:    slp_w_q <= fetch_data;
              4'h7:    pkg_w_q <= fetch_data;
              // RL13 crc kept for software check
              4'h8:    crc_q   <= fetch_data;
              // RL14 radio IQ trim
              4'h9:    iq_q    <= fetch_data;
              4'hA:    mark2_q <= fetch_data;
              default: mark1_q <= fetch_data;
            endcase
            if (slot_q == `OHB_FETCH_COUNT - 4'h1)
            begin
              state_q     <= ST_MIRROR;
              hdr_valid_q <= 1'b1;
            end
            else
            begin
              slot_q     <= slot_q + 4'h1;
              fetch_go_q <= 1'b1;
            end
          end
        end
        // RL18 hardware copy finishes before the processor runs
        ST_MIRROR:
        begin
          if (mdone_s)
          begin
            // RL19 wake-up skips the boot code stage
            if (cold_q)
              state_q <= ST_WAITSW;
            else
              state_q <= ST_RUN;
          end
        end
        ST_WAITSW:
        begin
          if (boot_go_q)
          begin
            state_q <= ST_RUN;
            cold_q  <= 1'b0;
          end
        end
        ST_RUN:
        begin
          if (wake_s)
            state_q <= ST_SLEEP;
        end
        ST_SLEEP:
        begin
          // wake path reruns the power stage, cold flag stays clear
          if (!wake_s)
            state_q <= ST_POWER;
        end
        default:
          state_q <= ST_POWER;
      endcase
    end
  end

  // ********************
  // registered outputs
  // ********************
  always @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      REG_EN_O       <= 1'b0;
      MEM_RD_O       <= 1'b0;
      MEM_ADDR_O     <= 15'h0000;
      MIRROR_START_O <= 1'b0;
      MIRROR_LEN_O   <= 32'h00000000;
      CPU_RUN_O      <= 1'b0;
      NORMAL_MODE_O  <= 1'b0;
      DEBUG_EN_O     <= 1'b1;
      SLEEP_RC_SEL_O <= 1'b0;
      PACKAGE_O      <= `OHB_PKG_UNKNOWN;
      SIG_SEL_O      <= `OHB_SIG_NONE;
      IQ_TRIM_O      <= 32'h00000000;
    end
    else
    begin
      // RL17 regulators held on outside sleep
      REG_EN_O       <= (state_q != ST_SLEEP);
      MEM_RD_O       <= mem_rd;
      MEM_ADDR_O     <= mem_addr;
      // RL16 mirroring only after header fetch
      MIRROR_START_O <= (state_q == ST_MIRROR);
      MIRROR_LEN_O   <= len_q;
      CPU_RUN_O      <= (state_q == ST_RUN) || (state_q == ST_WAITSW);
      // RL7 normal boot only with both markers
      NORMAL_MODE_O  <= hdr_valid_q && app_ok;
      // RL8 blank or unknown keeps debug on
      DEBUG_EN_O     <= !(hdr_valid_q && dbg_off);
      // RL3 RL21 only replicated AA selects the RC
      SLEEP_RC_SEL_O <= hdr_valid_q && (slp_w_q == rep4(`OHB_CODE_AA));
      PACKAGE_O      <= pkg_dec;
      SIG_SEL_O      <= sig_dec;
      IQ_TRIM_O      <= iq_q;
    end
  end

  // ********************
  // apb read side
  // ********************
  reg [31:0] rd_mux;
  reg        rd_bad;
  always @*
  begin
    rd_bad = 1'b0;
    case (PADDR_I)
      `OHB_REG_CTRL:       rd_mux = {31'h0, boot_go_q};
      `OHB_REG_STATUS:     rd_mux = {21'h0, sig_dec, pkg_dec, dbg_off,
                                     slp_w_q == rep4(`OHB_CODE_AA), app_ok,
                                     cold_q, hdr_valid_q, state_q[0]};
      `OHB_REG_CAL:        rd_mux = {cal_done, cal_w_q[31:16] == `OHB_CAL_NONE,
                                     24'h000000, cal_valid};
      `OHB_REG_MIRROR_LEN: rd_mux = len_q;
      `OHB_REG_DEV_ADDR0:  rd_mux = dev0_q;
      `OHB_REG_DEV_ADDR1:  rd_mux = dev1_q;
      `OHB_REG_IQ_TRIM:    rd_mux = iq_q;
      `OHB_REG_TRIM_CRC:   rd_mux = crc_q;
      default:
      begin
        rd_mux = 32'h00000000;
        rd_bad = 1'b1;
      end
    endcase
  end

  // answer in the cycle after setup, so access phase is one cycle
  always @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      PRDATA_O  <= 32'h00000000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PREADY_O  <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I && rd_bad;
      if (PSEL_I && !PENABLE_I && !PWRITE_I)
        PRDATA_O <= rd_mux;
    end
  end

endmodule // ohb_boot_decoder
`default_nettype wire

//--- design/ohb_consts.vh
// constants for the configuration header boot decoder
`ifndef OHB_CONSTS_VH
`define OHB_CONSTS_VH
// header word byte addresses
`define OHB_ADDR_DBG_EN      15'h7FFC
`define OHB_ADDR_MIRROR_LEN  15'h7FF8
`define OHB_ADDR_DEV_ADDR0   15'h7FD4
`define OHB_ADDR_DEV_ADDR1   15'h7FD8
`define OHB_ADDR_SIG_SEL     15'h7FD0
`define OHB_ADDR_CAL_FLAGS   15'h7F78
`define OHB_ADDR_SLEEP_SRC   15'h7F74
`define OHB_ADDR_PACKAGE     15'h7F70
`define OHB_ADDR_TRIM_CRC    15'h7F0C
`define OHB_ADDR_IQ_TRIM     15'h7F08
`define OHB_ADDR_APP_MARK2   15'h7F04
`define OHB_ADDR_APP_MARK1   15'h7F00
// flag codes
`define OHB_CAL_DONE         16'hA5A5
`define OHB_CAL_NONE         16'h0000
`define OHB_CAL_VALID_MSB    5
`define OHB_CODE_00          8'h00
`define OHB_CODE_AA          8'hAA
`define OHB_CODE_55          8'h55
`define OHB_CODE_99          8'h99
`define OHB_CODE_FF          8'hFF
`define OHB_APP_MARK1_VAL    32'h1234A5A5
`define OHB_APP_MARK2_VAL    32'hA5A51234
// package encodings
`define OHB_PKG_CSP34        3'h0
`define OHB_PKG_QFN40        3'h1
`define OHB_PKG_QFN48        3'h2
`define OHB_PKG_BARE_DIE     3'h3
`define OHB_PKG_UNKNOWN      3'h4
// signature encodings
`define OHB_SIG_NONE         2'h0
`define OHB_SIG_MD5          2'h1
`define OHB_SIG_SHA1         2'h2
`define OHB_SIG_CRC32        2'h3
// apb register byte offsets
`define OHB_REG_CTRL         8'h00
`define OHB_REG_STATUS       8'h04
`define OHB_REG_CAL          8'h08
`define OHB_REG_MIRROR_LEN   8'h0C
`define OHB_REG_DEV_ADDR0    8'h10
`define OHB_REG_DEV_ADDR1    8'h14
`define OHB_REG_IQ_TRIM      8'h18
`define OHB_REG_TRIM_CRC     8'h1C
// ctrl bit positions and reset
`define OHB_CTRL_BOOT_GO     0
`define OHB_CTRL_RESET_VAL   32'h00000000
// header fetch count
`define OHB_FETCH_COUNT      4'hC
`endif

//--- design/ohb_word_fetch.v
// one-word read requester toward the programmable memory
`timescale 1ns/10ps
`default_nettype none
`include "ohb_consts.vh"
module ohb_word_fetch
(
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // request from the sequencer
  input  wire        start_i,
  input  wire [14:0] addr_i,
  output reg         done_o,
  output reg  [31:0] data_o,
  // memory read port, read only
  output reg         mem_rd_o,
  output reg  [14:0] mem_addr_o,
  input  wire        mem_ack_i,
  input  wire [31:0] mem_rdata_i
);

  // read strobe held until the memory acknowledges
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      done_o     <= 1'b0;
      data_o     <= 32'h00000000;
      mem_rd_o   <= 1'b0;
      mem_addr_o <= 15'h0000;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i && !mem_rd_o)
      begin
        mem_rd_o   <= 1'b1;
        mem_addr_o <= addr_i;
      end
      else if (mem_rd_o && mem_ack_i)
      begin
        mem_rd_o <= 1'b0;
        data_o   <= mem_rdata_i;
        done_o   <= 1'b1;
      end
    end
  end

endmodule // ohb_word_fetch
`default_nettype wire

//--- tb/ohb_props.sv
// assertion checker for the header boot decoder
`timescale 1ns/10ps
`default_nettype none
`include "ohb_consts.vh"
module ohb_props
(
  // clock, reset and apb
  input wire        CLOCK_I,
  input wire        RST_N_I,
  input wire        PSEL_I,
  input wire        PENABLE_I,
  input wire        PWRITE_I,
  input wire [7:0]  PADDR_I,
  input wire [31:0] PRDATA_O,
  input wire        PREADY_O,
  input wire        PSLVERR_O,
  // stages and memory
  input wire        REG_EN_O,
  input wire        MEM_RD_O,
  input wire [14:0] MEM_ADDR_O,
  input wire        MEM_ACK_I,
  input wire [31:0] MEM_RDATA_I,
  input wire        MIRROR_START_O,
  input wire [31:0] MIRROR_LEN_O,
  input wire        CPU_RUN_O,
  input wire        NORMAL_MODE_O,
  input wire        DEBUG_EN_O,
  input wire [2:0]  PACKAGE_O
);
  logic [31:0] len_seen_q;
  wire         setup = PSEL_I && !PENABLE_I;
  // last length word seen on the memory port
  always @(posedge CLOCK_I or negedge RST_N_I)
    if (!RST_N_I)
      len_seen_q <= 32'h0;
    else if (MEM_ACK_I && MEM_ADDR_O == `OHB_ADDR_MIRROR_LEN)
      len_seen_q <= MEM_RDATA_I;
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);
  apb_answer_a: assert property (setup |=> PREADY_O)
    else $error("apb access not answered in one cycle");
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held beyond one cycle");
  slverr_ready_a: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  unmapped_err_a: assert property (setup && !PWRITE_I && PADDR_I > 8'h1C
    |=> PSLVERR_O && PRDATA_O == 32'h0)
    else $error("unmapped access not refused");
  hdr_addr_a: assert property (MEM_RD_O |-> MEM_ADDR_O[14:8] == 7'h7F && MEM_ADDR_O[1:0] == 2'h0
    && !(MEM_ADDR_O inside {[15'h7F10:15'h7F6C]}))
    else $error("read outside decoded header words");
  stage_order_a: assert property (MIRROR_START_O |-> !MEM_RD_O && !CPU_RUN_O)
    else $error("mirroring overlaps fetch or processor");
  run_powered_a: assert property (CPU_RUN_O |-> REG_EN_O)
    else $error("processor runs without regulators");
  mirror_len_a: assert property ($rose(MIRROR_START_O) |-> MIRROR_LEN_O == len_seen_q)
    else $error("mirror length differs from header");
  reset_dflt_a: assert property (disable iff (1'b0)
    !RST_N_I |-> DEBUG_EN_O && PACKAGE_O == 3'h4 && !CPU_RUN_O)
    else $error("reset defaults wrong");
  cover property (CPU_RUN_O && NORMAL_MODE_O);
  cover property (CPU_RUN_O && !NORMAL_MODE_O);
  cover property (PSLVERR_O);
  cover property ($rose(MIRROR_START_O));
endmodule // ohb_props
bind ohb_boot_decoder ohb_props u_props (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .REG_EN_O(REG_EN_O), .MEM_RD_O(MEM_RD_O), .MEM_ADDR_O(MEM_ADDR_O),
  .MEM_ACK_I(MEM_ACK_I), .MEM_RDATA_I(MEM_RDATA_I), .MIRROR_START_O(MIRROR_START_O),
  .MIRROR_LEN_O(MIRROR_LEN_O), .CPU_RUN_O(CPU_RUN_O), .NORMAL_MODE_O(NORMAL_MODE_O),
  .DEBUG_EN_O(DEBUG_EN_O), .PACKAGE_O(PACKAGE_O));
`default_nettype wire

//--- tb/ohb_otp_model.sv
// header memory model answering single word reads
`timescale 1ns/10ps
`default_nettype none
module ohb_otp_model
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        slow_i,
  input  wire logic        rd_i,
  input  wire logic [14:0] addr_i,
  output var  logic        ack_o,
  output var  logic [31:0] rdata_o
);
  logic [31:0] hdr [0:63];
  logic [14:0] log_q [$];
  logic [14:0] last_q;
  logic        served_q;
  logic [1:0]  cnt_q;
  // one ack per request; data toggles when not valid
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_o <= 1'b0;
      rdata_o <= 32'h0;
      served_q <= 1'b0;
      cnt_q <= 2'h0;
      log_q.delete();
    end
    else
    begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (!rd_i)
        served_q <= 1'b0;
      else if (!ack_o && (!served_q || addr_i != last_q))
      begin
        if (cnt_q == (slow_i ? 2'h3 : 2'h0))
        begin
          ack_o <= 1'b1;
          rdata_o <= hdr[addr_i[7:2]];
          served_q <= 1'b1;
          last_q <= addr_i;
          cnt_q <= 2'h0;
          log_q.push_back(addr_i);
        end
        else
          cnt_q <= cnt_q + 2'h1;
      end
    end
  end
endmodule // ohb_otp_model
`default_nettype wire

//--- tb/otp_header_boot_decoder_tb.sv
// self-checking bench for the header boot decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module otp_header_boot_decoder_tb;
  // reset starts high so the first assertion is a real falling edge
  logic clk = 0, rst_n = 1, psel = 0, penable = 0, pwrite = 0, wake = 0, sgood = 0;
  logic mdone = 0, slow = 0, pready, pslverr, reg_en, mem_rd, mem_ack, mir_start, cpu_run;
  logic normal, dbg_en, rc_sel, err;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, mem_rdata, mlen, iq, rd;
  logic [14:0] mem_addr;
  logic [2:0]  pkg;
  logic [1:0]  sig;
  wire  [2:0]  st = {mir_start, cpu_run, reg_en};
  int failures = 0, cmp_count = 0;
  logic [14:0] order_t [12] = '{15'h7FFC, 15'h7FF8, 15'h7FD4, 15'h7FD8, 15'h7FD0, 15'h7F78,
    15'h7F74, 15'h7F70, 15'h7F0C, 15'h7F08, 15'h7F04, 15'h7F00};
  always #5 clk = ~clk;
  ohb_boot_decoder DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .WAKE_REQ_I(wake), .SUPPLY_GOOD_I(sgood),
    .REG_EN_O(reg_en), .MEM_RD_O(mem_rd), .MEM_ADDR_O(mem_addr), .MEM_ACK_I(mem_ack),
    .MEM_RDATA_I(mem_rdata), .MIRROR_START_O(mir_start), .MIRROR_LEN_O(mlen),
    .MIRROR_DONE_I(mdone), .CPU_RUN_O(cpu_run), .NORMAL_MODE_O(normal), .DEBUG_EN_O(dbg_en),
    .SLEEP_RC_SEL_O(rc_sel), .PACKAGE_O(pkg), .SIG_SEL_O(sig), .IQ_TRIM_O(iq));
  ohb_otp_model mem (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .rd_i(mem_rd),
    .addr_i(mem_addr), .ack_o(mem_ack), .rdata_o(mem_rdata));
  // ***************
  // expectations
  // ***************
  function automatic logic [31:0] pick();
    case ($urandom % 7)
      0: return 32'h0;
      1: return 32'hAAAAAAAA;
      2: return 32'h55555555;
      3: return 32'h99999999;
      4: return 32'hFFFFFFFF;
      5: return 32'hAAAAAA00;
      default: return $urandom;
    endcase
  endfunction
  function automatic logic [2:0] exp_pkg(input logic [31:0] w);
    return w == 32'h0 ? 3'h0 : w == 32'hAAAAAAAA ? 3'h1 : w == 32'h55555555 ? 3'h2 :
      w == 32'h99999999 ? 3'h3 : 3'h4;
  endfunction
  function automatic logic [1:0] exp_sig(input logic [31:0] w);
    return w == 32'hAAAAAAAA ? 2'h1 : w == 32'h55555555 ? 2'h2 : w == 32'hFFFFFFFF ? 2'h3 : 2'h0;
  endfunction
  function automatic logic [31:0] exp_cal(input logic [31:0] w);
    return {w[31:16] == 16'hA5A5, w[31:16] == 16'h0, 24'h0, w[31:16] == 16'hA5A5 ? w[5:0] : 6'h0};
  endfunction
  function automatic logic [31:0] exp_stat(input logic cold);
    return {21'h0, exp_sig(mem.hdr[52]), exp_pkg(mem.hdr[28]), mem.hdr[63] == 32'hAAAAAAAA,
      mem.hdr[29] == 32'hAAAAAAAA, mem.hdr[0] == 32'h1234A5A5 && mem.hdr[1] == 32'hA5A51234,
      cold, 2'h0};
  endfunction
  // ***************
  // bus and waits
  // ***************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) failures++;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK("apb read data", e, rd & m)
    `CHK("apb error", ee, err)
  endtask
  task automatic wait_on(input int w, input logic v);
    int n;
    n = 0;
    while (st[w] !== v && n < 2000) begin @(posedge clk); n++; end
    if (n >= 2000) failures++;
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #500000;
    failures++;
    tally_and_finish();
  end
  // ***************
  // main sequence
  // ***************
  initial
  begin
    void'($urandom(25));
    for (int it = 0; it < 9; it++)
    begin
      foreach (mem.hdr[k]) mem.hdr[k] = $urandom;
      // hand-written corners first, so every defined flag code is seen
      mem.hdr[63] = it == 0 ? 32'h0 : it == 5 ? 32'hAAAAAAAA : pick();
      mem.hdr[29] = it == 0 ? 32'h0 : it == 4 ? 32'hAAAAAAAA : pick();
      mem.hdr[28] = it == 0 ? 32'h0 : it == 1 ? 32'hAAAAAAAA : it == 2 ? 32'h55555555 :
        it == 3 ? 32'h99999999 : pick();
      mem.hdr[52] = it == 1 ? 32'hAAAAAAAA : it == 2 ? 32'h55555555 : it == 3 ? 32'hFFFFFFFF :
        pick();
      mem.hdr[30][31:16] = it % 3 == 0 ? 16'hA5A5 : it % 3 == 1 ? 16'h0 : 16'($urandom);
      mem.hdr[0] = 32'h1234A5A5;
      mem.hdr[1] = 32'hA5A51234;
      if (it % 3 != 0) mem.hdr[it % 2] ^= 32'h1 << ($urandom % 32);
      rst_n <= 1'b0;
      sgood <= 1'b0;
      mdone <= 1'b0;
      slow <= it % 2;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      sgood <= 1'b1;
      wait_on(2, 1'b1);
      for (int k = 0; k < 12; k++) `CHK("fetch order", order_t[k], mem.log_q[k])
      `CHK("run before mirror", 1'b0, cpu_run)
      mdone <= 1'b1;
      wait_on(1, 1'b1);
      `CHK("mirror length", mem.hdr[62], mlen)
      `CHK("debug enable", mem.hdr[63] != 32'hAAAAAAAA, dbg_en)
      `CHK("sleep rc select", mem.hdr[29] == 32'hAAAAAAAA, rc_sel)
      `CHK("package", exp_pkg(mem.hdr[28]), pkg)
      `CHK("signature", exp_sig(mem.hdr[52]), sig)
      `CHK("iq trim", mem.hdr[2], iq)
      `CHK("normal mode", mem.hdr[0] == 32'h1234A5A5 && mem.hdr[1] == 32'hA5A51234, normal)
      rchk(8'h08, 32'hFFFFFFFF, exp_cal(mem.hdr[30]), 1'b0);
      rchk(8'h10, 32'hFFFFFFFF, mem.hdr[53], 1'b0);
      rchk(8'h14, 32'hFFFFFFFF, mem.hdr[54], 1'b0);
      rchk(8'h1C, 32'hFFFFFFFF, mem.hdr[3], 1'b0);
      rchk(8'h04, 32'h7FC, exp_stat(1'b1), 1'b0);
      rchk(8'h20 + 8'(4 * ($urandom % 56)), 32'hFFFFFFFF, 32'h0, 1'b1);
      apb(1'b1, 8'h00, 32'h1);
      rchk(8'h00, 32'h1, 32'h1, 1'b0);
      rchk(8'h04, 32'h7FC, exp_stat(1'b0), 1'b0);
      mdone <= 1'b0;
    end
    wake <= 1'b1;
    wait_on(0, 1'b0);
    `CHK("run in sleep", 1'b0, cpu_run)
    wake <= 1'b0;
    wait_on(2, 1'b1);
    mdone <= 1'b1;
    wait_on(1, 1'b1);
    rchk(8'h04, 32'h4, 32'h0, 1'b0);
    tally_and_finish();
  end
endmodule // otp_header_boot_decoder_tb
`default_nettype wire
